// File: oscsg_clock_ctrl.v
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "oscsg_defines.vh"

// Function
// - slow internal oscillator off until enabled
// - slow internal stable after 6/18/66/258 edges
// - slow internal stable flag reads its state
// - root defaults to divided internal fast
// - root select picks among four sources
// - selected source cannot be disabled by software
// - peripheral clocks run only while bit set
// - some peripherals gate configuration clock only
// - count edges after start-up, then stable
// - too few edges in time means failed
// - stable clears on disable, sets on restart
// - running failures leave stable flag alone
// - stable mirror never raises interrupt
// - ready flag on rise, cleared writing zero
// - slow external stable after 256..16384 edges
module oscsg_clock_ctrl #(
	parameter FE_DET_US      = 65000,
	parameter FE_DET_LONG_US = 130000,
	parameter SE_DET_US      = 1000000,
	parameter SE_DET_LONG_US = 2000000,
	parameter FI_DET_US      = 1000,
	parameter SI_DET_US      = 100000
) (
	input  wire        clk,
	input  wire        srst,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        external_fast_clock,
	input  wire        external_slow_clock,
	input  wire        internal_fast_oscillator,
	input  wire        internal_slow_oscillator,
	output wire        fast_external_osc_enable,
	output wire        external_slow_osc_enable,
	output wire        fast_internal_osc_enable,
	output wire        slow_internal_osc_enable,
	output wire [1:0]  root_clock_select,
	output wire [10:0] fast_internal_trim,
	output wire [9:0]  slow_internal_trim,
	output wire [31:0] ahb_cfg_clk_en,
	output wire [31:0] ahb_work_clk_en,
	output wire [31:0] apb_a_cfg_clk_en,
	output wire [31:0] apb_a_work_clk_en,
	output wire [31:0] apb_b_cfg_clk_en,
	output wire [31:0] apb_b_work_clk_en,
	output wire        irq
);
	localparam [31:0] FE_DET_CYC      = FE_DET_US * `OSCSG_CLK_MHZ;
	localparam [31:0] FE_DET_LONG_CYC = FE_DET_LONG_US * `OSCSG_CLK_MHZ;
	localparam [31:0] SE_DET_CYC      = SE_DET_US * `OSCSG_CLK_MHZ;
	localparam [31:0] SE_DET_LONG_CYC = SE_DET_LONG_US * `OSCSG_CLK_MHZ;
	localparam [31:0] FI_DET_CYC      = FI_DET_US * `OSCSG_CLK_MHZ;
	localparam [31:0] SI_DET_CYC      = SI_DET_US * `OSCSG_CLK_MHZ;

	reg  [1:0]  root_sel_q;
	reg  [3:0]  osc_en_q;
	reg  [10:0] fi_trim_q;
	reg  [9:0]  si_trim_q;
	reg  [1:0]  si_wait_q;
	reg  [1:0]  fe_wait_q;
	reg  [1:0]  se_wait_q;
	reg  [1:0]  fi_wait_q;
	reg  [3:0]  ready_q;
	reg  [3:0]  fail_flag_q;
	reg  [3:0]  stable_d1_q;
	reg  [7:0]  ier_q;
	reg  [31:0] ahben_q;
	reg  [31:0] apbena_q;
	reg  [31:0] apbenb_q;
	reg  [31:0] rdata_d;

	reg  [3:0]  sel_onehot;
	reg  [3:0]  osc_en_eff;
	reg  [18:0] fe_target;
	reg  [18:0] se_target;
	reg  [18:0] fi_target;
	reg  [18:0] si_target;
	reg  [31:0] fe_timeout;
	reg  [31:0] se_timeout;

	wire [3:0]  stable;
	wire [3:0]  fail;
	wire [3:0]  ready_set;
	wire [3:0]  ready_clr;
	wire [3:0]  fail_clr;
	wire        icr_wr;
	wire [11:0] isr_value;

	// one-hot of the source now feeding the root
	always @* begin
		sel_onehot = 4'h0;
		case (root_sel_q)
		`OSCSG_SEL_EXT_FAST: sel_onehot[`OSCSG_IDX_EXT_FAST] = 1'b1;
		`OSCSG_SEL_EXT_SLOW: sel_onehot[`OSCSG_IDX_EXT_SLOW] = 1'b1;
		`OSCSG_SEL_INT_FAST: sel_onehot[`OSCSG_IDX_INT_FAST] = 1'b1;
		`OSCSG_SEL_INT_SLOW: sel_onehot[`OSCSG_IDX_INT_SLOW] = 1'b1;
		default:             sel_onehot = 4'h0;
		endcase
		osc_en_eff = osc_en_q | sel_onehot;
	end

	// edge count per wait select
	always @* begin
		case (si_wait_q)
		2'h0:    si_target = `OSCSG_SI_CNT0;
		2'h1:    si_target = `OSCSG_SI_CNT1;
		2'h2:    si_target = `OSCSG_SI_CNT2;
		default: si_target = `OSCSG_SI_CNT3;
		endcase
		case (se_wait_q)
		2'h0:    se_target = `OSCSG_SE_CNT0;
		2'h1:    se_target = `OSCSG_SE_CNT1;
		2'h2:    se_target = `OSCSG_SE_CNT2;
		default: se_target = `OSCSG_SE_CNT3;
		endcase
		case (fe_wait_q)
		2'h0:    fe_target = `OSCSG_FE_CNT0;
		2'h1:    fe_target = `OSCSG_FE_CNT1;
		2'h2:    fe_target = `OSCSG_FE_CNT2;
		default: fe_target = `OSCSG_FE_CNT3;
		endcase
		case (fi_wait_q)
		2'h0:    fi_target = `OSCSG_FI_CNT0;
		2'h1:    fi_target = `OSCSG_FI_CNT1;
		2'h2:    fi_target = `OSCSG_FI_CNT2;
		default: fi_target = `OSCSG_FI_CNT3;
		endcase
		fe_timeout = (fe_wait_q == 2'h3) ? FE_DET_LONG_CYC : FE_DET_CYC;
		se_timeout = (se_wait_q == 2'h3) ? SE_DET_LONG_CYC : SE_DET_CYC;
	end

	oscsg_monitor u_mon_fe (
		.clk            (clk),
		.srst           (srst),
		.osc_en         (osc_en_eff[`OSCSG_IDX_EXT_FAST]),
		.osc_level      (external_fast_clock),
		.edge_target    (fe_target),
		.timeout_cycles (fe_timeout),
		.stable_q       (stable[`OSCSG_IDX_EXT_FAST]),
		.fail_q         (fail[`OSCSG_IDX_EXT_FAST])
	);

	oscsg_monitor u_mon_se (
		.clk            (clk),
		.srst           (srst),
		.osc_en         (osc_en_eff[`OSCSG_IDX_EXT_SLOW]),
		.osc_level      (external_slow_clock),
		.edge_target    (se_target),
		.timeout_cycles (se_timeout),
		.stable_q       (stable[`OSCSG_IDX_EXT_SLOW]),
		.fail_q         (fail[`OSCSG_IDX_EXT_SLOW])
	);

	oscsg_monitor u_mon_fi (
		.clk            (clk),
		.srst           (srst),
		.osc_en         (osc_en_eff[`OSCSG_IDX_INT_FAST]),
		.osc_level      (internal_fast_oscillator),
		.edge_target    (fi_target),
		.timeout_cycles (FI_DET_CYC),
		.stable_q       (stable[`OSCSG_IDX_INT_FAST]),
		.fail_q         (fail[`OSCSG_IDX_INT_FAST])
	);

	oscsg_monitor u_mon_si (
		.clk            (clk),
		.srst           (srst),
		.osc_en         (osc_en_eff[`OSCSG_IDX_INT_SLOW]),
		.osc_level      (internal_slow_oscillator),
		.edge_target    (si_target),
		.timeout_cycles (SI_DET_CYC),
		.stable_q       (stable[`OSCSG_IDX_INT_SLOW]),
		.fail_q         (fail[`OSCSG_IDX_INT_SLOW])
	);

	// interrupt flags, set beats clear
	assign icr_wr    = reg_wr & (reg_addr == `OSCSG_ADDR_ICR);
	assign ready_set = stable & ~stable_d1_q;
	assign ready_clr = icr_wr ? ~reg_wdata[`OSCSG_ISR_READY_LSB +: 4] : 4'h0;
	assign fail_clr  = icr_wr ? ~reg_wdata[`OSCSG_ISR_FAIL_LSB +: 4] : 4'h0;
	assign isr_value = {fail_flag_q, ready_q, stable};
	// stable mirror stays out of the request
	assign irq = |({fail_flag_q, ready_q} & ier_q);

	always @(posedge clk) begin
		if (srst) begin
			stable_d1_q <= 4'h0;
			ready_q     <= 4'h0;
			fail_flag_q <= 4'h0;
		end else begin
			stable_d1_q <= stable;
			ready_q     <= (ready_q & ~ready_clr) | ready_set;
			fail_flag_q <= (fail_flag_q & ~fail_clr) | fail;
		end
	end

	// register writes
	always @(posedge clk) begin
		if (srst) begin
			root_sel_q <= `OSCSG_SEL_RESET;
			osc_en_q   <= `OSCSG_EN_RESET;
			fi_trim_q  <= `OSCSG_TRIM_RESET;
			si_trim_q  <= `OSCSG_TRIM_SLOW_RESET;
			si_wait_q  <= `OSCSG_WAIT_SI_RESET;
			fe_wait_q  <= `OSCSG_WAIT_FE_RESET;
			se_wait_q  <= `OSCSG_WAIT_SE_RESET;
			fi_wait_q  <= `OSCSG_WAIT_FI_RESET;
			ier_q      <= 8'h00;
			ahben_q    <= `OSCSG_ZERO32;
			apbena_q   <= `OSCSG_ZERO32;
			apbenb_q   <= `OSCSG_ZERO32;
		end else if (reg_wr) begin
			case (reg_addr)
			`OSCSG_ADDR_CTRL0: root_sel_q <= reg_wdata[1:0];
			// selected source keeps its enable
			`OSCSG_ADDR_CTRL1: osc_en_q <= reg_wdata[3:0] | sel_onehot;
			`OSCSG_ADDR_FIOSC: begin
				fi_trim_q <= reg_wdata[`OSCSG_TRIM_FAST_W-1:0];
				fi_wait_q <= reg_wdata[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB];
			end
			`OSCSG_ADDR_SIOSC: begin
				si_trim_q <= reg_wdata[`OSCSG_TRIM_SLOW_W-1:0];
				si_wait_q <= reg_wdata[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB];
			end
			`OSCSG_ADDR_FEOSC: fe_wait_q <= reg_wdata[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB];
			`OSCSG_ADDR_SEOSC: se_wait_q <= reg_wdata[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB];
			`OSCSG_ADDR_IER:   ier_q <= reg_wdata[7:0];
			`OSCSG_ADDR_AHBEN:   ahben_q <= reg_wdata;
			`OSCSG_ADDR_APBEN_A: apbena_q <= reg_wdata;
			`OSCSG_ADDR_APBEN_B: apbenb_q <= reg_wdata;
			default: begin
			end
			endcase
		end
	end

	// read mux, data one cycle after the strobe
	always @* begin
		rdata_d = `OSCSG_ZERO32;
		case (reg_addr)
		`OSCSG_ADDR_CTRL0: rdata_d[1:0] = root_sel_q;
		`OSCSG_ADDR_CTRL1: rdata_d[3:0] = osc_en_q;
		`OSCSG_ADDR_FIOSC: begin
			rdata_d[`OSCSG_TRIM_FAST_W-1:0]           = fi_trim_q;
			rdata_d[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB] = fi_wait_q;
			rdata_d[`OSCSG_STABLE_BIT]               = stable[`OSCSG_IDX_INT_FAST];
		end
		`OSCSG_ADDR_SIOSC: begin
			rdata_d[`OSCSG_TRIM_SLOW_W-1:0]           = si_trim_q;
			rdata_d[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB] = si_wait_q;
			rdata_d[`OSCSG_STABLE_BIT]               = stable[`OSCSG_IDX_INT_SLOW];
		end
		`OSCSG_ADDR_FEOSC: begin
			rdata_d[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB] = fe_wait_q;
			rdata_d[`OSCSG_STABLE_BIT]               = stable[`OSCSG_IDX_EXT_FAST];
		end
		`OSCSG_ADDR_SEOSC: begin
			rdata_d[`OSCSG_WAIT_MSB:`OSCSG_WAIT_LSB] = se_wait_q;
			rdata_d[`OSCSG_STABLE_BIT]               = stable[`OSCSG_IDX_EXT_SLOW];
		end
		`OSCSG_ADDR_ISR:     rdata_d[`OSCSG_ISR_W-1:0] = isr_value;
		`OSCSG_ADDR_IER:     rdata_d[7:0] = ier_q;
		`OSCSG_ADDR_AHBEN:   rdata_d = ahben_q;
		`OSCSG_ADDR_APBEN_A: rdata_d = apbena_q;
		`OSCSG_ADDR_APBEN_B: rdata_d = apbenb_q;
		default:             rdata_d = `OSCSG_ZERO32;
		endcase
	end

	always @(posedge clk) begin
		if (srst)
			reg_rdata <= `OSCSG_ZERO32;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= `OSCSG_ZERO32;
	end

	assign fast_external_osc_enable = osc_en_eff[`OSCSG_IDX_EXT_FAST];
	assign external_slow_osc_enable = osc_en_eff[`OSCSG_IDX_EXT_SLOW];
	assign fast_internal_osc_enable = osc_en_eff[`OSCSG_IDX_INT_FAST];
	assign slow_internal_osc_enable = osc_en_eff[`OSCSG_IDX_INT_SLOW];
	assign root_clock_select        = root_sel_q;
	assign fast_internal_trim       = fi_trim_q;
	assign slow_internal_trim       = si_trim_q;

	// peripheral gating
	assign ahb_cfg_clk_en    = ahben_q;
	assign apb_a_cfg_clk_en  = apbena_q;
	assign apb_b_cfg_clk_en  = apbenb_q;
	assign ahb_work_clk_en   = ahben_q & ~`OSCSG_AHB_CFG_ONLY;
	assign apb_a_work_clk_en = apbena_q & ~`OSCSG_APBA_CFG_ONLY;
	assign apb_b_work_clk_en = apbenb_q & ~`OSCSG_APBB_CFG_ONLY;
endmodule
`default_nettype wire

// File: oscsg_clock_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module oscsg_clock_ctrl_bench;
	logic        clk, srst, reg_wr, reg_rd;
	logic        external_fast_clock, external_slow_clock;
	logic        internal_fast_oscillator, internal_slow_oscillator;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, r, d;
	logic [15:0] seed;
	wire  [31:0] reg_rdata, ahb_cfg_clk_en, ahb_work_clk_en, apb_a_cfg_clk_en;
	wire  [31:0] apb_a_work_clk_en, apb_b_cfg_clk_en, apb_b_work_clk_en;
	wire         fast_external_osc_enable, external_slow_osc_enable, irq;
	wire         fast_internal_osc_enable, slow_internal_osc_enable;
	wire  [1:0]  root_clock_select;
	wire  [10:0] fast_internal_trim;
	wire  [9:0]  slow_internal_trim;
	int          mismatches, compares, cycles, i, w, t;
	oscsg_clock_ctrl #(.FE_DET_US(2), .SE_DET_US(4), .SE_DET_LONG_US(8),
		.FI_DET_US(40), .SI_DET_US(40)) i_oscsg_clock_ctrl (.clk, .srst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .external_fast_clock, .external_slow_clock,
		.internal_fast_oscillator, .internal_slow_oscillator, .fast_external_osc_enable,
		.external_slow_osc_enable, .fast_internal_osc_enable, .slow_internal_osc_enable,
		.root_clock_select, .fast_internal_trim, .slow_internal_trim, .ahb_cfg_clk_en,
		.ahb_work_clk_en, .apb_a_cfg_clk_en, .apb_a_work_clk_en, .apb_b_cfg_clk_en,
		.apb_b_work_clk_en, .irq);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// oscillators toggle every cycle, external fast stays dead
	always @(posedge clk) begin
		internal_fast_oscillator <= ~internal_fast_oscillator;
		internal_slow_oscillator <= ~internal_slow_oscillator;
		external_slow_clock <= ~external_slow_clock;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	function automatic logic [31:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[15:0] = seed;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[31:16] = seed;
	endfunction
	function int si_target(input int c);
		si_target = (c == 0) ? 6 : (c == 1) ? 18 : (c == 2) ? 66 : 258;
	endfunction
	function [31:0] rst_val(input [7:0] a);
		rst_val = (a == 8'h00) ? 2 : (a == 8'h04) ? 4 : (a == 8'h10 || a == 8'h14) ? 32'h0000_2000 : 0;
	endfunction
	task wr(input [7:0] a, input [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{srst, seed, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 16'h41B8, 42'h0};
		{external_fast_clock, external_slow_clock} = 2'b00;
		{internal_fast_oscillator, internal_slow_oscillator, mismatches, compares, cycles} = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		#1 chk("slow enable", 0, slow_internal_osc_enable);
		chk("root", 2, root_clock_select);
		for (i = 0; i < 14; i++) begin
			rd(4 * i);
			chk("reset value", rst_val(4 * i), d);
		end
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			r = rnd();
			if (i == 0) r = 32'hFFFF_FFFF;
			wr(8'h24, r);
			wr(8'h28, ~r);
			wr(8'h2C, r);
			chk("ahb cfg", r, ahb_cfg_clk_en);
			chk("ahb work", r & ~32'h0000_0002, ahb_work_clk_en);
			chk("apb a cfg", ~r, apb_a_cfg_clk_en);
			chk("apb a work", ~r, apb_a_work_clk_en);
			chk("apb b cfg", r, apb_b_cfg_clk_en);
			chk("apb b work", r & ~32'h0000_0111, apb_b_work_clk_en);
			rd(8'h2C);
			chk("apb b read", r, d);
			wr(8'h08, r & 32'h0000_07FF);
			chk("fast trim", r[10:0], fast_internal_trim);
		end
		$display("test gating done");
		for (w = 0; w < 4; w++) begin
			r = rnd();
			t = si_target(w);
			wr(8'h0C, (w << 12) | (r & 32'h0000_03FF));
			chk("slow trim", r[9:0], slow_internal_trim);
			wr(8'h20, 32'h0000_0008);
			wr(8'h04, 32'h0000_000C);
			repeat (2 * t + 15) @(posedge clk);
			rd(8'h0C);
			chk("early stable", 0, d[15]);
			repeat (2) @(posedge clk);
			rd(8'h18);
			chk("stable ready", 3, {d[3], d[7]});
			chk("ready irq", 1, irq);
			wr(8'h04, 32'h0000_0004);
			wr(8'h1C, 32'hFFFF_FF7F);
			rd(8'h18);
			chk("cleared", 0, {d[3], d[7], irq});
		end
		$display("test slow internal done");
		wr(8'h1C, 32'h0000_0000);
		wr(8'h20, 32'h0000_000F);
		rd(8'h18);
		chk("mirror no irq", 2, {d[2], irq});
		wr(8'h20, 32'h0000_0010);
		wr(8'h14, 32'h0000_0000);
		wr(8'h04, 32'h0000_0007);
		repeat (600) @(posedge clk);
		rd(8'h18);
		chk("fail flags", 5, {d[8], d[0], d[1]});
		chk("fail irq", 1, irq);
		wr(8'h04, 32'h0000_0004);
		wr(8'h1C, 32'h0000_0000);
		chk("fail irq clear", 0, irq);
		wr(8'h20, 32'h0000_0000);
		chk("masked irq", 0, irq);
		$display("test external done");
		for (w = 0; w < 4; w++) begin
			wr(8'h00, w);
			wr(8'h04, 32'h0000_0000);
			rd(8'h04);
			chk("kept enable", 1 << w, d);
			chk("enable out", 1 << w, {slow_internal_osc_enable, fast_internal_osc_enable,
				external_slow_osc_enable, fast_external_osc_enable});
			chk("root select", w, root_clock_select);
		end
		wr(8'h00, 32'h0000_0002);
		rd(8'h40);
		chk("unmapped read", 0, d);
		$display("test root select done");
		tally_and_finish;
	end
endmodule
bind oscsg_clock_ctrl oscsg_clock_ctrl_properties i_oscsg_clock_ctrl_properties (.clk, .srst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fast_external_osc_enable,
	.external_slow_osc_enable, .fast_internal_osc_enable, .slow_internal_osc_enable,
	.root_clock_select, .fast_internal_trim, .ahb_cfg_clk_en, .ahb_work_clk_en,
	.apb_b_cfg_clk_en, .apb_b_work_clk_en, .irq);
`default_nettype wire

// File: oscsg_clock_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "oscsg_defines.vh"
module oscsg_clock_ctrl_properties (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        fast_external_osc_enable,
	input wire logic        external_slow_osc_enable,
	input wire logic        fast_internal_osc_enable,
	input wire logic        slow_internal_osc_enable,
	input wire logic [1:0]  root_clock_select,
	input wire logic [10:0] fast_internal_trim,
	input wire logic [31:0] ahb_cfg_clk_en,
	input wire logic [31:0] ahb_work_clk_en,
	input wire logic [31:0] apb_b_cfg_clk_en,
	input wire logic [31:0] apb_b_work_clk_en,
	input wire logic        irq
);
	wire [3:0] en;
	assign en = {slow_internal_osc_enable, fast_internal_osc_enable,
		external_slow_osc_enable, fast_external_osc_enable};
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero when idle");
	slow_off_a: assert property ($rose(slow_internal_osc_enable) |->
		$past(reg_wr && reg_addr == 8'h04 && reg_wdata[3]) || root_clock_select == 2'h3)
		else $error("slow oscillator started without enable");
	root_reset_a: assert property ($fell(srst) |-> root_clock_select == 2'h2)
		else $error("root select not default after reset");
	sel_write_a: assert property (reg_wr && reg_addr == 8'h00 |=>
		root_clock_select == $past(reg_wdata[1:0]))
		else $error("root select not written");
	root_held_a: assert property (en[root_clock_select])
		else $error("selected source disabled");
	work_gate_a: assert property (ahb_work_clk_en == (ahb_cfg_clk_en & ~`OSCSG_AHB_CFG_ONLY) &&
		apb_b_work_clk_en == (apb_b_cfg_clk_en & ~`OSCSG_APBB_CFG_ONLY))
		else $error("working clock gating wrong");
	cfg_write_a: assert property (reg_wr && reg_addr == 8'h24 |=>
		ahb_cfg_clk_en == $past(reg_wdata))
		else $error("clock enable not written");
	trim_write_a: assert property (reg_wr && reg_addr == 8'h08 |=>
		fast_internal_trim == $past(reg_wdata[10:0]))
		else $error("fast trim not written");
	stable_clear_a: assert property (reg_rd && reg_addr == 8'h18 && !slow_internal_osc_enable &&
		!$past(slow_internal_osc_enable) |=> !reg_rdata[3])
		else $error("stable flag set while off");
	mirror_no_irq_a: assert property (reg_wr && reg_addr == 8'h20 &&
		reg_wdata[7:0] == 8'h00 |=> !irq)
		else $error("interrupt with all masks off");
	cover property (reg_rd && reg_addr == 8'h18 ##1 reg_rdata[7]);
	cover property ($rose(irq));
	cover property (root_clock_select == 2'h3);
endmodule
`default_nettype wire

// File: oscsg_defines.vh
`ifndef OSCSG_DEFINES_VH
`define OSCSG_DEFINES_VH

// clock rate
`define OSCSG_CLK_MHZ          250

// register byte addresses
`define OSCSG_ADDR_CTRL0       8'h00
`define OSCSG_ADDR_CTRL1       8'h04
`define OSCSG_ADDR_FIOSC       8'h08
`define OSCSG_ADDR_SIOSC       8'h0C
`define OSCSG_ADDR_FEOSC       8'h10
`define OSCSG_ADDR_SEOSC       8'h14
`define OSCSG_ADDR_ISR         8'h18
`define OSCSG_ADDR_ICR         8'h1C
`define OSCSG_ADDR_IER         8'h20
`define OSCSG_ADDR_AHBEN       8'h24
`define OSCSG_ADDR_APBEN_A     8'h28
`define OSCSG_ADDR_APBEN_B     8'h2C

// root clock select codes
`define OSCSG_SEL_EXT_FAST     2'h0
`define OSCSG_SEL_EXT_SLOW     2'h1
`define OSCSG_SEL_INT_FAST     2'h2
`define OSCSG_SEL_INT_SLOW     2'h3
`define OSCSG_SEL_RESET        2'h2

// source index in enable, stable, ready and fail vectors
`define OSCSG_IDX_EXT_FAST     0
`define OSCSG_IDX_EXT_SLOW     1
`define OSCSG_IDX_INT_FAST     2
`define OSCSG_IDX_INT_SLOW     3

// enable register: internal fast on, the rest off
`define OSCSG_EN_RESET         4'h4

// oscillator control register fields
`define OSCSG_TRIM_FAST_W      11
`define OSCSG_TRIM_SLOW_W      10
`define OSCSG_TRIM_RESET       11'h000
`define OSCSG_TRIM_SLOW_RESET  10'h000
`define OSCSG_WAIT_LSB         12
`define OSCSG_WAIT_MSB         13
`define OSCSG_STABLE_BIT       15
`define OSCSG_WAIT_SI_RESET    2'h0
`define OSCSG_WAIT_FE_RESET    2'h2
`define OSCSG_WAIT_SE_RESET    2'h2
`define OSCSG_WAIT_FI_RESET    2'h0

// interrupt register fields
`define OSCSG_ISR_STABLE_LSB   0
`define OSCSG_ISR_READY_LSB    4
`define OSCSG_ISR_FAIL_LSB     8
`define OSCSG_ISR_W            12

// edge counts, slow internal
`define OSCSG_SI_CNT0          19'h0_0006
`define OSCSG_SI_CNT1          19'h0_0012
`define OSCSG_SI_CNT2          19'h0_0042
`define OSCSG_SI_CNT3          19'h0_0102
// edge counts, slow external
`define OSCSG_SE_CNT0          19'h0_0100
`define OSCSG_SE_CNT1          19'h0_0400
`define OSCSG_SE_CNT2          19'h0_1000
`define OSCSG_SE_CNT3          19'h0_4000
// edge counts, fast external
`define OSCSG_FE_CNT0          19'h0_2000
`define OSCSG_FE_CNT1          19'h0_8000
`define OSCSG_FE_CNT2          19'h2_0000
`define OSCSG_FE_CNT3          19'h4_0000
// edge counts, fast internal
`define OSCSG_FI_CNT0          19'h0_0040
`define OSCSG_FI_CNT1          19'h0_0100
`define OSCSG_FI_CNT2          19'h0_0400
`define OSCSG_FI_CNT3          19'h0_1000

// start-up phase length, edges ignored meanwhile
`define OSCSG_STARTUP_CYCLES   8'h10

// peripheral bits that gate only the configuration clock
`define OSCSG_AHB_CFG_ONLY     32'h0000_0002
`define OSCSG_APBA_CFG_ONLY    32'h0000_0000
`define OSCSG_APBB_CFG_ONLY    32'h0000_0111

`define OSCSG_ZERO32           32'h0000_0000

`endif

// File: oscsg_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "oscsg_defines.vh"

module oscsg_monitor (
	input  wire        clk,
	input  wire        srst,
	input  wire        osc_en,
	input  wire        osc_level,
	input  wire [18:0] edge_target,
	input  wire [31:0] timeout_cycles,
	output reg         stable_q,
	output reg         fail_q
);
	localparam [4:0] ST_OFF    = 5'h01;
	localparam [4:0] ST_START  = 5'h02;
	localparam [4:0] ST_COUNT  = 5'h04;
	localparam [4:0] ST_STABLE = 5'h08;
	localparam [4:0] ST_FAIL   = 5'h10;

	reg  [4:0]  state_q;
	reg  [7:0]  start_q;
	reg  [18:0] edges_q;
	reg  [31:0] timer_q;
	reg         level_q;
	wire        rise;
	wire        timeout;

	assign rise    = osc_level & ~level_q;
	assign timeout = (timer_q >= timeout_cycles);

	always @(posedge clk) begin
		if (srst) begin
			state_q  <= ST_OFF;
			start_q  <= 8'h00;
			edges_q  <= 19'h0_0000;
			timer_q  <= `OSCSG_ZERO32;
			level_q  <= 1'b0;
			stable_q <= 1'b0;
			fail_q   <= 1'b0;
		end else begin
			level_q <= osc_level;
			fail_q  <= 1'b0;
			if (!osc_en) begin
				state_q  <= ST_OFF;
				start_q  <= 8'h00;
				edges_q  <= 19'h0_0000;
				timer_q  <= `OSCSG_ZERO32;
				stable_q <= 1'b0;
			end else begin
				case (state_q)
				ST_OFF: begin
					state_q <= ST_START;
				end
				ST_START: begin
					timer_q <= timer_q + 32'h0000_0001;
					start_q <= start_q + 8'h01;
					if (start_q >= `OSCSG_STARTUP_CYCLES)
						state_q <= ST_COUNT;
				end
				ST_COUNT: begin
					timer_q <= timer_q + 32'h0000_0001;
					if (rise)
						edges_q <= edges_q + 19'h0_0001;
					if (edges_q >= edge_target) begin
						state_q  <= ST_STABLE;
						stable_q <= 1'b1;
					end else if (timeout) begin
						state_q <= ST_FAIL;
						fail_q  <= 1'b1;
					end
				end
				ST_STABLE: begin
					state_q <= ST_STABLE;
				end
				ST_FAIL: begin
					state_q <= ST_FAIL;
				end
				default: begin
					state_q <= ST_OFF;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire
